// *** hw/payload_byte_compare.sv ***
/*
 One payload byte comparison slot.
 Assumes the payload length is already reduced to 0..8.
*/
`timescale 1ns/100ps
module payload_byte_compare #(
	parameter logic [3:0] INDEX = 4'h0
) (
	// Bytes
	input wire logic [7:0] expected_in,
	input wire logic [7:0] received_in,
	// Length
	input wire logic [3:0] length_in,
	// Result
	output logic ok_out
);
	wire in_use = INDEX < length_in;

	assign ok_out = !in_use || (expected_in == received_in);
endmodule

// *** hw/selective_wake_frame_config.sv ***
/*
 Selective wake frame configuration: length code, expected payload,
 FD tolerant settings and receiver selection, with frame qualification.
 Assumes register accesses and received frame fields come from decoded
 logic on mclk_in, so no synchronisers are needed.
*/
`timescale 1ns/100ps
`include "swk_defines.svh"
module selective_wake_frame_config (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic nrst_in,
	// Register access
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [6:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	output logic [15:0] reg_rdata_out,
	output logic reg_rvalid_out,
	// Received frame
	input wire logic rx_frame_valid_in,
	input wire logic [3:0] rx_length_code_in,
	input wire logic [63:0] rx_payload_in,
	input wire logic silence_timeout_in,
	// Frame result
	output logic match_valid_out,
	output logic length_match_out,
	output logic payload_match_out,
	output logic frame_match_out,
	// Configuration to the wake logic
	output logic [3:0] payload_length_out,
	output logic fd_tolerant_enable_out,
	output logic error_counter_suspend_out,
	output logic [2:0] dominant_filter_time_out,
	output logic [3:0] dominant_filter_cycles_out,
	output logic wake_receiver_select_out
);
	// ----------------------------------------
	// Filter times in clock cycles
	// ----------------------------------------
	localparam int C50 = (`FILT_50_NS * `CLOCK_MHZ + 999) / 1000;
	localparam int C100 = (`FILT_100_NS * `CLOCK_MHZ + 999) / 1000;
	localparam int C150 = (`FILT_150_NS * `CLOCK_MHZ + 999) / 1000;
	localparam int C200 = (`FILT_200_NS * `CLOCK_MHZ + 999) / 1000;
	localparam int C250 = (`FILT_250_NS * `CLOCK_MHZ + 999) / 1000;
	localparam int C300 = (`FILT_300_NS * `CLOCK_MHZ + 999) / 1000;
	localparam int C775 = (`FILT_775_NS * `CLOCK_MHZ + 999) / 1000;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [3:0] length_code_r;
	logic [15:0] bytes_7_6_r;
	logic [15:0] bytes_5_4_r;
	logic [15:0] bytes_3_2_r;
	logic [15:0] bytes_1_0_r;
	logic fd_enable_r;
	wake_frame_pkg::filter_sel_t filter_r;
	logic suspend_r;
	logic suspend_nxt;
	logic rx_select_r;
	logic [15:0] rdata_r;
	logic rvalid_r;
	logic match_valid_r;
	logic length_match_r;
	logic payload_match_r;
	logic [3:0] filter_cycles_r;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire sel_length = reg_addr_in == `ADDR_LENGTH_CODE;
	wire sel_b76 = reg_addr_in == `ADDR_BYTES_7_6;
	wire sel_b54 = reg_addr_in == `ADDR_BYTES_5_4;
	wire sel_b32 = reg_addr_in == `ADDR_BYTES_3_2;
	wire sel_b10 = reg_addr_in == `ADDR_BYTES_1_0;
	wire sel_fd = reg_addr_in == `ADDR_FD_CONFIG;
	wire sel_rxs = reg_addr_in == `ADDR_RX_SELECT;
	wire wr_fd = reg_wr_in && sel_fd;

	wire [15:0] fd_word = {10'h000, suspend_r, 1'b0, filter_r, fd_enable_r};
	wire [15:0] length_word = {12'h000, length_code_r};
	wire [15:0] rxs_word = {1'b0, rx_select_r, 14'h0000};
	wire [15:0] read_word = sel_length ? length_word :
		sel_b76 ? bytes_7_6_r :
		sel_b54 ? bytes_5_4_r :
		sel_b32 ? bytes_3_2_r :
		sel_b10 ? bytes_1_0_r :
		sel_fd ? fd_word :
		sel_rxs ? rxs_word : `RESET_WORD;

	// Software write wins over the timeout clear in the same cycle
	assign suspend_nxt = wr_fd ? reg_wdata_in[`FD_SUSPEND_BIT] :
		silence_timeout_in ? 1'b0 : suspend_r;

	// ----------------------------------------
	// Payload length and comparison
	// ----------------------------------------
	wire [3:0] payload_length = length_code_r[3] ? `FULL_PAYLOAD_BYTES : length_code_r;
	wire [63:0] expected_payload = {bytes_7_6_r, bytes_5_4_r, bytes_3_2_r, bytes_1_0_r};
	wire [7:0] byte_ok;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_cmp
			payload_byte_compare #(
				.INDEX(4'(gi))
			) u_cmp (
				.expected_in(expected_payload[8*gi +: 8]),
				.received_in(rx_payload_in[8*gi +: 8]),
				.length_in(payload_length),
				.ok_out(byte_ok[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			length_code_r <= 4'h0;
			bytes_7_6_r <= `RESET_WORD;
			bytes_5_4_r <= `RESET_WORD;
			bytes_3_2_r <= `RESET_WORD;
			bytes_1_0_r <= `RESET_WORD;
			fd_enable_r <= 1'b0;
			filter_r <= wake_frame_pkg::FILT_50;
			suspend_r <= 1'b0;
			rx_select_r <= 1'b0;
		end else begin
			if (reg_wr_in && sel_length) begin
				length_code_r <= reg_wdata_in[3:0];
			end
			if (reg_wr_in && sel_b76) begin
				bytes_7_6_r <= reg_wdata_in;
			end
			if (reg_wr_in && sel_b54) begin
				bytes_5_4_r <= reg_wdata_in;
			end
			if (reg_wr_in && sel_b32) begin
				bytes_3_2_r <= reg_wdata_in;
			end
			if (reg_wr_in && sel_b10) begin
				bytes_1_0_r <= reg_wdata_in;
			end
			if (wr_fd) begin
				fd_enable_r <= reg_wdata_in[`FD_ENABLE_BIT];
				filter_r <= wake_frame_pkg::filter_sel_t'(reg_wdata_in[`DOMINANT_FILTER_MSB:`DOMINANT_FILTER_LSB]);
			end
			suspend_r <= suspend_nxt;
			if (reg_wr_in && sel_rxs) begin
				rx_select_r <= reg_wdata_in[`RX_SELECT_BIT];
			end
		end
	end

	// ----------------------------------------
	// Read port and frame result
	// ----------------------------------------
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			rdata_r <= `RESET_WORD;
			rvalid_r <= 1'b0;
			match_valid_r <= 1'b0;
			length_match_r <= 1'b0;
			payload_match_r <= 1'b0;
		end else begin
			rvalid_r <= reg_rd_in;
			if (reg_rd_in) begin
				rdata_r <= read_word;
			end
			match_valid_r <= rx_frame_valid_in;
			if (rx_frame_valid_in) begin
				length_match_r <= rx_length_code_in == length_code_r;
				payload_match_r <= &byte_ok;
			end
		end
	end

	// ----------------------------------------
	// Filter time to cycles
	// ----------------------------------------
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			filter_cycles_r <= 4'(C50);
		end else begin
			case (filter_r)
				wake_frame_pkg::FILT_50: filter_cycles_r <= 4'(C50);
				wake_frame_pkg::FILT_100: filter_cycles_r <= 4'(C100);
				wake_frame_pkg::FILT_150: filter_cycles_r <= 4'(C150);
				wake_frame_pkg::FILT_200: filter_cycles_r <= 4'(C200);
				wake_frame_pkg::FILT_250: filter_cycles_r <= 4'(C250);
				wake_frame_pkg::FILT_300: filter_cycles_r <= 4'(C300);
				default: filter_cycles_r <= 4'(C775);
			endcase
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata_out = rdata_r;
	assign reg_rvalid_out = rvalid_r;
	assign match_valid_out = match_valid_r;
	assign length_match_out = length_match_r;
	assign payload_match_out = payload_match_r;
	assign frame_match_out = length_match_r && payload_match_r;
	assign payload_length_out = payload_length;
	assign fd_tolerant_enable_out = fd_enable_r;
	assign error_counter_suspend_out = suspend_r && fd_enable_r;
	assign dominant_filter_time_out = filter_r;
	assign dominant_filter_cycles_out = filter_cycles_r;
	assign wake_receiver_select_out = rx_select_r;
endmodule

// *** hw/swk_defines.svh ***
/*
 Register offsets, field positions, reset values and timing figures of the
 selective wake frame configuration block.
 Assumes a 7-bit register address and 16-bit register data.
*/
// Summary of operation
// - The length code is four bits in bits 3:0; codes 0 to 7 mean that many bytes, and 0 also means cleared.
// - Length codes 8 to 15 all mean a payload of eight bytes.
// - A frame qualifies only if its length code equals the configured code in all four bits.
// - Each expected payload byte is eight bits with bit 0 the LSB and bit 7 the MSB.
// - Bytes pair into 16-bit registers, higher byte in 15:8, lower in 7:0, bytes 7 and 6 at the lowest address.
// - Bits 15:4 of the length register and bits 15:6 and 4 of the FD register read as zero.
// - Bit 0 of the FD register enables FD tolerant mode when one.
// - Bit 5 of the FD register suspends the error counter, but only while FD tolerant mode is on.
// - The suspend bit is cleared by the device when the bus silence timeout expires; a write to the FD register in the same cycle wins.
// - Bits 3:1 of the FD register select the dominant filter time from 50 ns to 775 ns.
// - The receiver select bit picks the low-power receiver at zero and the standard one at one.
`ifndef WAKE_FRAME_DEFINES_SVH
`define WAKE_FRAME_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_LENGTH_CODE 7'h36
`define ADDR_BYTES_7_6 7'h37
`define ADDR_BYTES_5_4 7'h38
`define ADDR_BYTES_3_2 7'h39
`define ADDR_BYTES_1_0 7'h3a
`define ADDR_FD_CONFIG 7'h3b
`define ADDR_RX_SELECT 7'h3c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FD_ENABLE_BIT 0
`define DOMINANT_FILTER_LSB 1
`define DOMINANT_FILTER_MSB 3
`define FD_SUSPEND_BIT 5
`define RX_SELECT_BIT 14
`define FULL_PAYLOAD_BYTES 4'h8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RESET_WORD 16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLOCK_MHZ 10
`define FILT_50_NS 50
`define FILT_100_NS 100
`define FILT_150_NS 150
`define FILT_200_NS 200
`define FILT_250_NS 250
`define FILT_300_NS 300
`define FILT_775_NS 775

`endif

// *** hw/swk_pkg.sv ***
/*
 Types of the selective wake frame configuration block.
 Assumes nothing of its surroundings.
*/
package wake_frame_pkg;

	typedef enum logic [2:0] {
		FILT_50 = 3'b000,
		FILT_100 = 3'b001,
		FILT_150 = 3'b010,
		FILT_200 = 3'b011,
		FILT_250 = 3'b100,
		FILT_300 = 3'b101,
		FILT_RSVD = 3'b110,
		FILT_775 = 3'b111
	} filter_sel_t;

endpackage

// *** verification/swk_checker.sv ***
/* Port assertions for selective_wake_frame_config.
 Assumes it is bound into that module and sees its ports only. */
`timescale 1ns/100ps
module wake_config_checker (
	// Clock, reset and register bus
	input wire logic mclk_in, nrst_in, reg_wr_in, reg_rd_in, silence_timeout_in,
	input wire logic [6:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in, reg_rdata_out,
	// Results and configuration
	input wire logic reg_rvalid_out, match_valid_out, length_match_out, payload_match_out, frame_match_out,
	input wire logic fd_tolerant_enable_out, error_counter_suspend_out, wake_receiver_select_out,
	input wire logic [3:0] payload_length_out,
	input wire logic [2:0] dominant_filter_time_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);
	wire wr_len = reg_wr_in && reg_addr_in == 7'h36;
	wire rd_len = reg_rd_in && reg_addr_in == 7'h36;
	wire wr_fd = reg_wr_in && reg_addr_in == 7'h3b;
	wire rd_fd = reg_rd_in && reg_addr_in == 7'h3b;
	wire wr_rx = reg_wr_in && reg_addr_in == 7'h3c;
	len_sat_a: assert property (wr_len && reg_wdata_in[3] |=> payload_length_out == 4'h8) else $error("long code");
	len_low_a: assert property (wr_len && !reg_wdata_in[3] |=> payload_length_out == $past(reg_wdata_in[3:0]))
		else $error("short code");
	len_hold_a: assert property (!wr_len |=> $stable(payload_length_out)) else $error("length moved");
	len_rsv_a: assert property (rd_len |=> reg_rvalid_out && reg_rdata_out[15:4] == 12'h000) else $error("len rsv");
	fd_rsv_a: assert property (rd_fd |=> reg_rdata_out[15:6] == 10'h000 && !reg_rdata_out[4]) else $error("fd rsv");
	fd_en_a: assert property (wr_fd |=> fd_tolerant_enable_out == $past(reg_wdata_in[0])) else $error("fd enable");
	susp_gate_a: assert property (error_counter_suspend_out |-> fd_tolerant_enable_out) else $error("suspend");
	filt_sel_a: assert property (wr_fd |=> dominant_filter_time_out == $past(reg_wdata_in[3:1])) else $error("filter");
	timeout_clr_a: assert property (silence_timeout_in && !wr_fd |=> !error_counter_suspend_out) else $error("timeout");
	rx_sel_a: assert property (wr_rx |=> wake_receiver_select_out == $past(reg_wdata_in[14])) else $error("rx select");
	match_and_a: assert property (match_valid_out |-> frame_match_out == (length_match_out && payload_match_out))
		else $error("frame match");
	rst_clr_a: assert property (disable iff (1'b0) !nrst_in |=> payload_length_out == 4'h0 && !fd_tolerant_enable_out)
		else $error("reset");
	cover property (match_valid_out && frame_match_out);
	cover property (error_counter_suspend_out ##1 !error_counter_suspend_out);
	cover property (rd_fd ##1 reg_rvalid_out);
endmodule
bind selective_wake_frame_config wake_config_checker chk (.*);

// *** verification/test_selective_wake_frame_config.sv ***
/* Bench for selective_wake_frame_config against a register model.
 Assumes wake_frame_sender and the bound checker. */
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; $display("Error %s exp %h got %h", n, e, g); end end
module test_selective_wake_frame_config;
	logic mclk_in = 1'b0, nrst_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, silence_timeout_in = 1'b0;
	logic [6:0] reg_addr_in = 7'h00;
	logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out;
	logic reg_rvalid_out, rx_frame_valid_in, match_valid_out, length_match_out, payload_match_out, frame_match_out;
	logic fd_tolerant_enable_out, error_counter_suspend_out, wake_receiver_select_out;
	logic [3:0] rx_length_code_in, payload_length_out, dominant_filter_cycles_out;
	logic [2:0] dominant_filter_time_out;
	logic [63:0] rx_payload_in, p;
	logic [15:0] m [7'h36:7'h3c];
	logic [3:0] cyc [8] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h8, 4'h8};
	int seed = 48166, num_errors = 0, checks = 0, n;
	initial begin
		forever #50 mclk_in = ~mclk_in;
	end
	wake_frame_sender fs (.mclk_in(mclk_in), .frame_valid_out(rx_frame_valid_in),
		.length_code_out(rx_length_code_in), .payload_out(rx_payload_in));
	selective_wake_frame_config uut (.*);
	function automatic logic [15:0] msk(input logic [6:0] a);
		msk = (a == 7'h36) ? 16'h000f : (a == 7'h3b) ? 16'h002f : (a == 7'h3c) ? 16'h4000 :
			(a > 7'h36 && a < 7'h3b) ? 16'hffff : 16'h0000;
	endfunction
	function automatic logic [7:0] eb(input int i);
		logic [15:0] w;
		w = m[7'h3a - i / 2];
		eb = (i % 2) ? w[15:8] : w[7:0];
	endfunction
	task idle;
		@(posedge mclk_in);
		#10;
	endtask
	task wr(input logic [6:0] a, input logic [15:0] v);
		reg_addr_in = a;
		reg_wdata_in = v;
		reg_wr_in = 1'b1;
		idle;
		reg_wr_in = 1'b0;
		if (msk(a) != 16'h0000) m[a] = v & msk(a);
		idle;
	endtask
	task rd(input logic [6:0] a);
		reg_addr_in = a;
		reg_rd_in = 1'b1;
		idle;
		reg_rd_in = 1'b0;
		`CHK("rvalid", 1'b1, reg_rvalid_out)
		`CHK("rdata", (msk(a) != 16'h0000) ? m[a] : 16'h0000, reg_rdata_out)
		idle;
	endtask
	task frm(input logic [3:0] c, input logic [63:0] pl);
		logic lm, pm;
		lm = (c == m[7'h36][3:0]);
		pm = 1'b1;
		n = m[7'h36][3] ? 8 : m[7'h36][3:0];
		for (int i = 0; i < n; i++)
			if (pl[8 * i +: 8] != eb(i)) pm = 1'b0;
		fs.send(c, pl);
		`CHK("mvalid", 1'b1, match_valid_out)
		`CHK("lmatch", lm, length_match_out)
		`CHK("pmatch", pm, payload_match_out)
		`CHK("fmatch", lm & pm, frame_match_out)
		idle;
	endtask
	task stop_test;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#(100 * 6000);
		num_errors++;
		stop_test;
	end
	initial begin
		foreach (m[a]) m[a] = 16'h0000;
		repeat (20) @(posedge mclk_in);
		#10 nrst_in = 1'b1;
		for (int a = 'h35; a < 'h3e; a++) rd(a[6:0]);
		`CHK("cycles", 4'h1, dominant_filter_cycles_out)
		$display("reset test done");
		for (int a = 'h36; a < 'h3e; a++) begin
			wr(a[6:0], 16'($random(seed)));
			rd(a[6:0]);
		end
		$display("readback test done");
		for (int c = 0; c < 16; c++) begin
			wr(7'h36, {12'($random(seed)), 4'(c)});
			`CHK("length", (c > 7) ? 4'h8 : 4'(c), payload_length_out)
			n = (c > 7) ? 8 : c;
			for (int i = 0; i < 8; i++) p[8 * i +: 8] = (i < n) ? eb(i) : 8'($random(seed));
			frm(4'(c), p);
			frm(4'(c) ^ 4'(1 << (c % 4)), p);
			if (c > 0) frm(4'(c), p ^ (64'h1 << (8 * (n - 1) + c % 8)));
		end
		$display("frame test done");
		for (int f = 0; f < 32; f++) begin
			wr(7'h3b, {10'($random(seed)), f[1], 1'($random(seed)), f[4:2], f[0]});
			`CHK("fd enable", f[0], fd_tolerant_enable_out)
			`CHK("suspend", f[1] & f[0], error_counter_suspend_out)
			`CHK("filter", f[4:2], dominant_filter_time_out)
			`CHK("cycles", cyc[f[4:2]], dominant_filter_cycles_out)
			rd(7'h3b);
		end
		silence_timeout_in = 1'b1;
		idle;
		silence_timeout_in = 1'b0;
		m[7'h3b][5] = 1'b0;
		`CHK("suspend", 1'b0, error_counter_suspend_out)
		rd(7'h3b);
		silence_timeout_in = 1'b1;
		reg_addr_in = 7'h3b;
		reg_wdata_in = 16'h0021;
		reg_wr_in = 1'b1;
		idle;
		silence_timeout_in = 1'b0;
		reg_wr_in = 1'b0;
		m[7'h3b] = 16'h0021;
		idle;
		`CHK("suspend", 1'b1, error_counter_suspend_out)
		rd(7'h3b);
		wr(7'h3c, 16'hffff);
		`CHK("rx select", 1'b1, wake_receiver_select_out)
		wr(7'h3c, 16'h0000);
		`CHK("rx select", 1'b0, wake_receiver_select_out)
		$display("fd test done");
		nrst_in = 1'b0;
		idle;
		nrst_in = 1'b1;
		foreach (m[a]) m[a] = 16'h0000;
		for (int a = 'h36; a < 'h3d; a++) rd(a[6:0]);
		`CHK("cycles", 4'h1, dominant_filter_cycles_out)
		`CHK("fd enable", 1'b0, fd_tolerant_enable_out)
		`CHK("suspend", 1'b0, error_counter_suspend_out)
		$display("soft reset test done");
		stop_test;
	end
endmodule

// *** verification/wake_frame_sender.sv ***
/* CAN node model handing received wake-up frames to the block.
 Assumes calls start just after a rising edge of mclk_in. */
`timescale 1ns/100ps
module wake_frame_sender (
	// Clock
	input wire logic mclk_in,
	// Frame fields
	output logic frame_valid_out = 1'b0,
	output logic [3:0] length_code_out = 4'h0,
	output logic [63:0] payload_out = 64'h0
);
	// Fields stand one cycle, then the lines show their inverse
	task send(input logic [3:0] code, input logic [63:0] data);
		frame_valid_out = 1'b1;
		length_code_out = code;
		payload_out = data;
		@(posedge mclk_in);
		#10;
		frame_valid_out = 1'b0;
		length_code_out = ~code;
		payload_out = ~data;
	endtask
endmodule
